// >>> hdl/sys_reset_params.svh
// constants of the reset and break status register bank
// assumes an 8-bit cpu register port and a 20 MHz system clock
// Function
// - reading reset source register clears it
// - power-on sets its flag, clears others
// - flags accumulate, later resets other than power-on never clear
// - drive reset pin low during internal resets
// - sample pin 32 oscillator cycles after release
// - external pin reset sets pin flag
// - watchdog reset sets watchdog flag
// - illegal opcode reset sets its flag
// - illegal address flag only for opcode fetches
// - usb bus reset sets usb flag
// - low voltage reset sets its flag
// - break ending wait sets break wait flag
// - break status register for emulation only
// - break clear enable gates flag clearing
// - two-step clears stay protected in break
// - flag cleared in break stays cleared
`ifndef SYS_RESET_PARAMS_SVH
`define SYS_RESET_PARAMS_SVH
`define ADDR_BREAK_STATUS        16'hFE00
`define ADDR_RESET_SOURCE        16'hFE01
`define ADDR_BREAK_FLAG_CONTROL  16'hFE03
`define BIT_BREAK_WAIT           1
`define BIT_LOW_VOLTAGE          1
`define BIT_USB                  2
`define BIT_ILLEGAL_ADDRESS      3
`define BIT_ILLEGAL_OPCODE       4
`define BIT_WATCHDOG             5
`define BIT_PIN                  6
`define BIT_POWER_ON             7
`define BIT_BREAK_CLEAR_ENABLE   7
`define RESET_SOURCE_POR_VALUE   8'h80
`define PIN_SAMPLE_OSC_CYCLES    32
`define PIN_STRETCH_CYCLES       32
`endif

// >>> hdl/sys_reset_pkg.sv
// types of the reset and break status register bank
// assumes the params header is compiled alongside
package sys_reset_pkg;
   typedef enum logic [2:0]
   {
      PIN_IDLE   = 3'b001,
      PIN_DRIVE  = 3'b010,
      PIN_SAMPLE = 3'b100
   } pin_state_t;
endpackage

// >>> hdl/pin_sampler_if.sv
// carrier between the bank and its reset pin sequencer
// assumes one clock domain
`timescale 1ns/10ps
`default_nettype none
interface pin_sampler_if;
   logic start;
   logic pin_low_late;
   logic drive_low;
   modport bank (output start, input pin_low_late, input drive_low);
   modport seq  (input start, output pin_low_late, output drive_low);
endinterface
`default_nettype wire

// >>> hdl/reset_pin_sequencer.sv
// drives the reset pin low for an internal reset, then samples it later
// assumes rst_pin_sync is already synchronised to clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "sys_reset_params.svh"
module reset_pin_sequencer
   import sys_reset_pkg::*;
#(
   parameter int STRETCH = `PIN_STRETCH_CYCLES,
   parameter int SAMPLE  = `PIN_SAMPLE_OSC_CYCLES
)
(
   input  wire logic   clk_sys,
   input  wire logic   sys_rst,
   input  wire logic   rst_pin_sync,
   pin_sampler_if.seq  ps
);
   pin_state_t state;
   pin_state_t next_state;
   logic [7:0] count;
   logic [7:0] next_count;
   logic       next_low_late;
   logic       low_late;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_state    = state;
      next_count    = count;
      next_low_late = 1'b0;
      case (state)
         PIN_IDLE:
         begin
            if (ps.start)
            begin
               next_state = PIN_DRIVE;
               next_count = 8'(STRETCH - 1);
            end
         end
         PIN_DRIVE:
         begin
            if (count == 8'h00)
            begin
               next_state = PIN_SAMPLE;
               next_count = 8'(SAMPLE - 1);
            end
            else
               next_count = count - 8'h01;
         end
         PIN_SAMPLE:
         begin
            // a new internal reset inside the sample window must pull the pin again
            if (ps.start)
            begin
               next_state = PIN_DRIVE;
               next_count = 8'(STRETCH - 1);
            end
            else if (count == 8'h00)
            begin
               next_state    = PIN_IDLE;
               next_low_late = ~rst_pin_sync;
            end
            else
               next_count = count - 8'h01;
         end
         default:
            next_state = PIN_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state    <= PIN_DRIVE;
         count    <= 8'(STRETCH - 1);
         low_late <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         count    <= next_count;
         low_late <= next_low_late;
      end
   end

   assign ps.drive_low    = (state == PIN_DRIVE);
   assign ps.pin_low_late = low_late;
endmodule
`default_nettype wire

// >>> hdl/system_reset_break_status_regs.sv
// reset source, break status and break flag control registers
// assumes reset causes arrive as one-cycle pulses on clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "sys_reset_params.svh"
module system_reset_break_status_regs
   import sys_reset_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        power_on_event,
   input  wire logic        pin_reset_event,
   input  wire logic        watchdog_event,
   input  wire logic        illegal_opcode_event,
   input  wire logic        illegal_address_event,
   input  wire logic        illegal_address_is_fetch,
   input  wire logic        usb_reset_event,
   input  wire logic        low_voltage_event,
   input  wire logic        wait_exit_event,
   input  wire logic        wait_exit_by_break,
   input  wire logic        break_state,
   input  wire logic        rst_pin_in,
   output logic             rst_pin_out,
   output logic             rst_pin_oe,
   output logic             reset_request_n,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_rd,
   input  wire logic        cpu_wr,
   input  wire logic [7:0]  cpu_wdata,
   output logic      [7:0]  cpu_rdata,
   output logic             flag_clear_allowed
);
   pin_sampler_if ps ();
   logic       pin_meta;
   logic       pin_sync;
   logic [7:0] reset_source;
   logic [7:0] next_reset_source;
   logic       break_wait;
   logic       next_break_wait;
   logic       clear_enable;
   logic       next_clear_enable;
   logic [7:0] next_rdata;
   logic       any_internal;
   logic       sel_bs;
   logic       sel_rs;
   logic       sel_fc;

   ////////////////////////////////////////////////////////////////////////
   // reset pin synchroniser
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
      end
      else
      begin
         pin_meta <= rst_pin_in;
         pin_sync <= pin_meta;
      end
   end

   reset_pin_sequencer u_seq
   (
      .clk_sys      (clk_sys),
      .sys_rst      (sys_rst),
      .rst_pin_sync (pin_sync),
      .ps           (ps.seq)
   );

   // open drain: only ever pull low
   assign rst_pin_out     = 1'b0;
   assign rst_pin_oe      = ps.drive_low;
   assign reset_request_n = ~ps.drive_low;

   ////////////////////////////////////////////////////////////////////////
   // decode
   assign sel_bs = (cpu_addr == `ADDR_BREAK_STATUS);
   assign sel_rs = (cpu_addr == `ADDR_RESET_SOURCE);
   assign sel_fc = (cpu_addr == `ADDR_BREAK_FLAG_CONTROL);

   // watchdog etc pulse the pin; pin reset itself does not restart it
   assign any_internal = watchdog_event | illegal_opcode_event | usb_reset_event
                       | low_voltage_event | (illegal_address_event & illegal_address_is_fetch);
   assign ps.start = any_internal;

   // other modules clear flags only outside break or when enabled
   assign flag_clear_allowed = ~break_state | clear_enable;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_reset_source = reset_source;
      next_break_wait   = break_wait;
      next_clear_enable = clear_enable;
      next_rdata        = 8'h00;
      // read returns pre-clear value, clear applied in same edge
      if (cpu_rd)
      begin
         if (sel_bs)
            next_rdata[`BIT_BREAK_WAIT] = break_wait;
         else if (sel_rs)
            next_rdata = reset_source;
         else if (sel_fc)
            next_rdata[`BIT_BREAK_CLEAR_ENABLE] = clear_enable;
      end
      // limitation: reading in break with clearing disabled keeps flags
      if (cpu_rd && sel_rs && flag_clear_allowed)
         next_reset_source = 8'h00;
      if (cpu_wr && sel_fc)
         next_clear_enable = cpu_wdata[`BIT_BREAK_CLEAR_ENABLE];
      // break wait flag cleared by writing zero, only when allowed
      if (cpu_wr && sel_bs && flag_clear_allowed && !cpu_wdata[`BIT_BREAK_WAIT])
         next_break_wait = 1'b0;
      // sets win over clears; flags accumulate, except power-on clears the others
      if (pin_reset_event || ps.pin_low_late)
         next_reset_source[`BIT_PIN] = 1'b1;
      if (watchdog_event)
         next_reset_source[`BIT_WATCHDOG] = 1'b1;
      if (illegal_opcode_event)
         next_reset_source[`BIT_ILLEGAL_OPCODE] = 1'b1;
      if (illegal_address_event && illegal_address_is_fetch)
         next_reset_source[`BIT_ILLEGAL_ADDRESS] = 1'b1;
      if (usb_reset_event)
         next_reset_source[`BIT_USB] = 1'b1;
      if (low_voltage_event)
         next_reset_source[`BIT_LOW_VOLTAGE] = 1'b1;
      if (wait_exit_event && wait_exit_by_break)
         next_break_wait = 1'b1;
      next_reset_source[0] = 1'b0;
      if (power_on_event)
         next_reset_source = `RESET_SOURCE_POR_VALUE;
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reset_source <= `RESET_SOURCE_POR_VALUE;
         break_wait   <= 1'b0;
         clear_enable <= 1'b0;
         cpu_rdata    <= 8'h00;
      end
      else
      begin
         reset_source <= next_reset_source;
         break_wait   <= next_break_wait;
         clear_enable <= next_clear_enable;
         cpu_rdata    <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/sys_reset_assertions.sv
// concurrent checks on the reset and break status register bank
// assumes binding onto the bank's top module ports
`timescale 1ns/10ps
`default_nettype none
`include "sys_reset_params.svh"
module sys_reset_assertions
(
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        watchdog_event,
   input wire logic        illegal_opcode_event,
   input wire logic        illegal_address_event,
   input wire logic        illegal_address_is_fetch,
   input wire logic        usb_reset_event,
   input wire logic        low_voltage_event,
   input wire logic        break_state,
   input wire logic        rst_pin_out,
   input wire logic        rst_pin_oe,
   input wire logic        reset_request_n,
   input wire logic [15:0] cpu_addr,
   input wire logic        cpu_rd,
   input wire logic [7:0]  cpu_rdata,
   input wire logic        flag_clear_allowed
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic [6:0] oe_cycles;
   // one edge of slack: the drive may still be sampled on the release edge
   always_ff @(posedge clk_sys or posedge sys_rst)
      if (sys_rst)
         oe_cycles <= 7'h00;
      else
         oe_cycles <= rst_pin_oe ? oe_cycles + 7'h01 : 7'h00;
   ////////////////////////////////////////////////////////////
   a_pin_pulled_low:
      assert property (rst_pin_oe |-> !rst_pin_out) else $error("pin driven high");
   a_request_tracks_pin:
      assert property (reset_request_n != rst_pin_oe) else $error("request out of step with pin");
   a_watchdog_drive:
      assert property (watchdog_event |=> rst_pin_oe) else $error("watchdog reset not driving pin");
   a_internal_drive:
      assert property (illegal_opcode_event || usb_reset_event || low_voltage_event
                       || (illegal_address_event && illegal_address_is_fetch) |=> rst_pin_oe)
         else $error("internal reset not driving pin");
   a_clear_open:
      assert property (!break_state |-> flag_clear_allowed) else $error("clearing blocked outside break");
   a_idle_zero:
      assert property (!cpu_rd |=> cpu_rdata == 8'h00) else $error("read data without read");
   a_source_bit0:
      assert property (cpu_rd && cpu_addr == `ADDR_RESET_SOURCE |=> !cpu_rdata[0]) else $error("bit0 set");
   a_control_bits:
      assert property (cpu_rd && cpu_addr == `ADDR_BREAK_FLAG_CONTROL |=> cpu_rdata[6:0] == 7'h00)
         else $error("control reserved bits set");
   a_status_bits:
      assert property (cpu_rd && cpu_addr == `ADDR_BREAK_STATUS |=> {cpu_rdata[7:2], cpu_rdata[0]} == 7'h00)
         else $error("status reserved bits set");
   a_stretch_bound:
      assert property (oe_cycles <= 7'h21) else $error("pin drive too long");
endmodule
bind system_reset_break_status_regs sys_reset_assertions checker_u (.clk_sys, .sys_rst, .watchdog_event,
   .illegal_opcode_event, .illegal_address_event, .illegal_address_is_fetch, .usb_reset_event,
   .low_voltage_event, .break_state, .rst_pin_out, .rst_pin_oe, .reset_request_n, .cpu_addr, .cpu_rd,
   .cpu_rdata, .flag_clear_allowed);
`default_nettype wire

// >>> testbench/system_reset_break_status_regs_test.sv
// self-checking bench for the reset and break status register bank
// assumes design files and checker compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "sys_reset_params.svh"
module system_reset_break_status_regs_test;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  ev      = 8'h00;
   logic        fetch   = 1'b1;
   logic        by_brk  = 1'b0;
   logic        brk     = 1'b0;
   logic        ext_low = 1'b0;
   logic [15:0] addr    = 16'h0000;
   logic        rd      = 1'b0;
   logic        wr      = 1'b0;
   logic [7:0]  wdata   = 8'h00;
   logic        pin_out;
   logic        pin_oe;
   logic        req_n;
   logic [7:0]  rdata;
   logic        clr_ok;
   int          mismatches = 0;
   int          checks_done = 0;
   // pin has a pull-up; an outside party may hold it low
   wire logic   pin = (pin_oe ? pin_out : 1'b1) & ~ext_low;
   always #25 clk_sys = ~clk_sys;
   system_reset_break_status_regs dut_u
   (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .power_on_event(ev[7]), .pin_reset_event(ev[6]),
      .watchdog_event(ev[5]), .illegal_opcode_event(ev[4]), .illegal_address_event(ev[3]),
      .illegal_address_is_fetch(fetch), .usb_reset_event(ev[2]), .low_voltage_event(ev[1]),
      .wait_exit_event(ev[0]), .wait_exit_by_break(by_brk), .break_state(brk), .rst_pin_in(pin),
      .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .reset_request_n(req_n), .cpu_addr(addr),
      .cpu_rd(rd), .cpu_wr(wr), .cpu_wdata(wdata), .cpu_rdata(rdata), .flag_clear_allowed(clr_ok)
   );
   ////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      addr = a;
      rd = 1'b1;
      @(negedge clk_sys);
      rd = 1'b0;
      chk($sformatf("read %h", a), exp, rdata);
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_sys);
      wr = 1'b0;
   endtask
   task automatic pulse(input logic [7:0] m);
      @(negedge clk_sys);
      ev = m;
      @(negedge clk_sys);
      ev = 8'h00;
   endtask
   // waits out the pin drive, then the sample window and synchroniser
   task automatic settle(input int exp_drive);
      int n;
      n = 0;
      chk("request", (exp_drive > 0) ? 8'h00 : 8'h01, {7'h00, req_n});
      while (pin_oe !== 1'b0 && n < 200)
      begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 200)
      begin
         mismatches++;
         wrap_up;
      end
      chk("drive cycles", 8'(exp_drive), 8'(n));
      repeat (40) @(negedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_power_on;
      rd_chk(`ADDR_RESET_SOURCE, 8'h80);
      rd_chk(`ADDR_RESET_SOURCE, 8'h00);
      rd_chk(`ADDR_BREAK_STATUS, 8'h00);
      wr_reg(`ADDR_BREAK_FLAG_CONTROL, 8'hFF);
      rd_chk(`ADDR_BREAK_FLAG_CONTROL, 8'h80);
      wr_reg(`ADDR_BREAK_FLAG_CONTROL, 8'h00);
   endtask
   task automatic t_sources;
      for (int i = 1; i < 7; i++)
      begin
         pulse(8'h01 << i);
         settle((i == 6) ? 0 : `PIN_STRETCH_CYCLES);
         rd_chk(`ADDR_RESET_SOURCE, 8'h01 << i);
         rd_chk(`ADDR_RESET_SOURCE, 8'h00);
      end
   endtask
   task automatic t_accumulate;
      pulse(8'h20);
      settle(`PIN_STRETCH_CYCLES);
      pulse(8'h04);
      settle(`PIN_STRETCH_CYCLES);
      rd_chk(`ADDR_RESET_SOURCE, 8'h24);
      pulse(8'h10);
      settle(`PIN_STRETCH_CYCLES);
      pulse(8'h80);
      settle(0);
      rd_chk(`ADDR_RESET_SOURCE, 8'h80);
      fetch = 1'b0;
      pulse(8'h08);
      settle(0);
      rd_chk(`ADDR_RESET_SOURCE, 8'h00);
      fetch = 1'b1;
   endtask
   task automatic t_pin_late;
      pulse(8'h02);
      ext_low = 1'b1;
      settle(`PIN_STRETCH_CYCLES);
      ext_low = 1'b0;
      rd_chk(`ADDR_RESET_SOURCE, 8'h42);
   endtask
   task automatic t_break;
      pulse(8'h01);
      rd_chk(`ADDR_BREAK_STATUS, 8'h00);
      by_brk = 1'b1;
      pulse(8'h01);
      by_brk = 1'b0;
      rd_chk(`ADDR_BREAK_STATUS, 8'h02);
      pulse(8'h20);
      settle(`PIN_STRETCH_CYCLES);
      brk = 1'b1;
      @(negedge clk_sys);
      chk("clear allowed", 8'h00, {7'h00, clr_ok});
      rd_chk(`ADDR_RESET_SOURCE, 8'h20);
      rd_chk(`ADDR_RESET_SOURCE, 8'h20);
      wr_reg(`ADDR_BREAK_STATUS, 8'h00);
      rd_chk(`ADDR_BREAK_STATUS, 8'h02);
      wr_reg(`ADDR_BREAK_FLAG_CONTROL, 8'h80);
      chk("clear allowed", 8'h01, {7'h00, clr_ok});
      rd_chk(`ADDR_RESET_SOURCE, 8'h20);
      rd_chk(`ADDR_RESET_SOURCE, 8'h00);
      wr_reg(`ADDR_BREAK_STATUS, 8'hFF);
      rd_chk(`ADDR_BREAK_STATUS, 8'h02);
      wr_reg(`ADDR_BREAK_STATUS, 8'h00);
      brk = 1'b0;
      rd_chk(`ADDR_RESET_SOURCE, 8'h00);
      rd_chk(`ADDR_BREAK_STATUS, 8'h00);
   endtask
   // second reset in mid-run, cutting an ongoing pin drive
   task automatic t_rerun;
      by_brk = 1'b1;
      pulse(8'h11);
      by_brk = 1'b0;
      rd_chk(`ADDR_BREAK_STATUS, 8'h02);
      @(negedge clk_sys);
      sys_rst = 1'b1;
      repeat (5) @(negedge clk_sys);
      sys_rst = 1'b0;
      settle(`PIN_STRETCH_CYCLES);
      rd_chk(`ADDR_RESET_SOURCE, 8'h80);
      rd_chk(`ADDR_BREAK_STATUS, 8'h00);
      rd_chk(`ADDR_BREAK_FLAG_CONTROL, 8'h00);
   endtask
   initial
   begin
      repeat (5) @(negedge clk_sys);
      sys_rst = 1'b0;
      settle(`PIN_STRETCH_CYCLES);
      t_power_on;
      t_sources;
      t_accumulate;
      t_pin_late;
      t_break;
      t_rerun;
      wrap_up;
   end
endmodule
`default_nettype wire
